// *** rtl/paxcfg_defs.svh ***
/*
 register offsets, field positions, reset values and timing figures for the
 proximity/ambient configuration and status register slice.
 assumes inclusion by bare name; definitions only.
*/
`ifndef PAXCFG_DEFS_SVH
`define PAXCFG_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PAX_OFS_PULSE_DRIVE 8'h8F
`define PAX_OFS_PW_LOW 8'h90
`define PAX_OFS_GAIN 8'h91
`define PAX_OFS_REVISION 8'h92
`define PAX_OFS_DEVTYPE 8'h93
`define PAX_OFS_FLAGS 8'h94

// ----------------------------------------
// reset values
// ----------------------------------------
`define PAX_RST_PULSE_DRIVE 8'h32
`define PAX_RST_PW_LOW 8'h20
`define PAX_RST_GAIN 8'h68
`define PAX_RST_FLAGS 8'h00
`define PAX_RST_FIRST_GAIN 2'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define PAX_PWH_MSB 7
`define PAX_PWH_LSB 6
`define PAX_RSVD_MSB 5
`define PAX_RSVD_LSB 4
`define PAX_DRV_MSB 3
`define PAX_DRV_LSB 0
`define PAX_G2_MSB 6
`define PAX_G2_LSB 5
`define PAX_AG_MSB 4
`define PAX_AG_LSB 0
`define PAX_GAIN_RSVD_BIT 7
`define PAX_REV_MSB 2
`define PAX_ID_LSB 2

// ----------------------------------------
// timing
// ----------------------------------------
`define PAX_CLK_NS 50
`define PAX_US_NS 1000
`define PAX_PW_EXTRA_US 2
`define PAX_PW_CODE_MAX 1023

`endif

// *** rtl/paxcfg_pkg.sv ***
/*
 types shared by the proximity/ambient register slice.
 assumes nothing beyond the defs header.
*/
package paxcfg_pkg;
   // ----------------------------------------
   // pulse generator states
   // ----------------------------------------
   typedef enum logic [1:0] {
      PAX_PULSE_IDLE = 2'b01,
      PAX_PULSE_ON = 2'b10
   } paxcfg_pulse_t;
endpackage

// *** rtl/paxcfg_regs.sv ***
/*
 configuration and status register slice of an ambient/proximity sensor:
 pulse width, drive current, gains, identification and eight event flags,
 plus a pulse timer that shapes each emitter pulse from the width code.
 assumes a register port from the serial management bus front end with
 one-cycle read and write strobes, and event pulses from the engines.
*/
`timescale 1ns/1ps
`include "paxcfg_defs.svh"

module paxcfg_regs #(
   parameter int PERS_WIDTH = 4,
   parameter logic [7:0] REVISION_CODE = 8'h05, // arbitrary value
   parameter logic [7:0] DEVTYPE_CODE = 8'hA8 // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic clear_on_read,
   input wire logic ambient_sat_evt,
   input wire logic prox_dark_phase_saturation,
   input wire logic prox_lit_phase_saturation,
   input wire logic prox_result_valid,
   input wire logic prox_out_of_range,
   input wire logic [PERS_WIDTH-1:0] prox_persistence_count,
   input wire logic ambient_persist_evt,
   input wire logic calib_done_evt,
   input wire logic automatic_offset_trim,
   input wire logic zero_result_evt,
   input wire logic emitter_fire,
   output logic emitter_on,
   output logic [3:0] emitter_drive_current,
   output logic [1:0] prox_first_stage_gain_out,
   output logic [1:0] prox_second_stage_gain,
   output logic [4:0] ambient_gain,
   output logic [4:0] prox_total_gain_exp2x
);
   import paxcfg_pkg::*;

   localparam int CYC_PER_US = (`PAX_US_NS + `PAX_CLK_NS - 1) / `PAX_CLK_NS;
   localparam int CNT_W = 16;

   // elaboration checks: widths the counters can serve
   if (PERS_WIDTH < 1 || PERS_WIDTH > 8) begin
      $error("persistence width out of range");
   end
   if ((`PAX_PW_CODE_MAX + `PAX_PW_EXTRA_US) * CYC_PER_US >= (1 << CNT_W)) begin
      $error("pulse timer too narrow for the longest pulse");
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [2:0] g2_exp2x(input logic [1:0] code);
      // second stage in half-steps: 2.5x taken as base, 5x one step, 10x two
      case (code)
         2'd0: g2_exp2x = 3'd0;
         2'd1: g2_exp2x = 3'd1;
         2'd3: g2_exp2x = 3'd2;
         default: g2_exp2x = 3'd2;
      endcase
   endfunction

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic [7:0] pulse_drive_reg, pulse_drive_next;
   logic [7:0] pw_low_reg, pw_low_next;
   logic [7:0] gain_reg, gain_next;
   logic [1:0] first_gain_reg, first_gain_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [PERS_WIDTH-1:0] pers_cnt_reg, pers_cnt_next;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic prox_hit;

   always_comb begin
      pulse_drive_next = pulse_drive_reg;
      pw_low_next = pw_low_reg;
      gain_next = gain_reg;
      first_gain_next = first_gain_reg;
      if (reg_wr) begin
         case (reg_addr)
            `PAX_OFS_PULSE_DRIVE: pulse_drive_next = reg_wdata;
            `PAX_OFS_PW_LOW: pw_low_next = reg_wdata;
            `PAX_OFS_GAIN: gain_next = reg_wdata;
            // id, revision and flag offsets store nothing
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pulse_drive_reg <= `PAX_RST_PULSE_DRIVE;
         pw_low_reg <= `PAX_RST_PW_LOW;
         gain_reg <= `PAX_RST_GAIN;
         first_gain_reg <= `PAX_RST_FIRST_GAIN;
      end else if (clk_en) begin
         pulse_drive_reg <= pulse_drive_next;
         pw_low_reg <= pw_low_next;
         gain_reg <= gain_next;
         first_gain_reg <= first_gain_next;
      end
   end

   // ----------------------------------------
   // proximity persistence counter
   // ----------------------------------------
   always_comb begin
      pers_cnt_next = pers_cnt_reg;
      prox_hit = 1'b0;
      if (prox_result_valid) begin
         if (!prox_out_of_range) begin
            pers_cnt_next = '0;
         end else begin
            if (pers_cnt_reg != {PERS_WIDTH{1'b1}}) begin
               pers_cnt_next = pers_cnt_reg + 1'b1;
            end
            // zero setting means every out-of-range valid result raises the flag
            prox_hit = (prox_persistence_count == '0) ||
               (pers_cnt_next == prox_persistence_count);
         end
      end
   end

   // count frozen with the rest while clk_en is low
   always_ff @(posedge mclk) begin
      if (rst) begin
         pers_cnt_reg <= '0;
      end else if (clk_en) begin
         pers_cnt_reg <= pers_cnt_next;
      end
   end

   // ----------------------------------------
   // event flags
   // ----------------------------------------
   always_comb begin
      set_vec = {ambient_sat_evt,
         prox_dark_phase_saturation | prox_lit_phase_saturation,
         prox_hit,
         ambient_persist_evt,
         calib_done_evt,
         automatic_offset_trim & zero_result_evt,
         prox_lit_phase_saturation,
         prox_dark_phase_saturation};
      clr_vec = 8'h00;
      if (reg_wr && reg_addr == `PAX_OFS_FLAGS) begin
         clr_vec = reg_wdata;
      end
      if (reg_rd && clear_on_read && reg_addr == `PAX_OFS_FLAGS) begin
         clr_vec = 8'hFF;
      end
      flags_next = (flags_reg & ~clr_vec) | set_vec;
   end

   // events arriving with clk_en low are lost, not queued
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_reg <= `PAX_RST_FLAGS;
      end else if (clk_en) begin
         flags_reg <= flags_next;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         case (reg_addr)
            `PAX_OFS_PULSE_DRIVE: rdata_next = pulse_drive_reg;
            `PAX_OFS_PW_LOW: rdata_next = pw_low_reg;
            `PAX_OFS_GAIN: rdata_next = gain_reg;
            `PAX_OFS_REVISION: rdata_next = {5'h00, REVISION_CODE[`PAX_REV_MSB:0]};
            `PAX_OFS_DEVTYPE: rdata_next = {DEVTYPE_CODE[7:`PAX_ID_LSB], 2'b00};
            // flags captured before the clear lands
            `PAX_OFS_FLAGS: rdata_next = flags_reg;
            // unmapped offsets read as zero
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // read data holds until the next read
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (clk_en) begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------
   // emitter pulse timer
   // ----------------------------------------
   paxcfg_pulse_t pstate_reg, pstate_next;
   logic [CNT_W-1:0] pcnt_reg, pcnt_next;
   logic [9:0] pw_code;
   logic [CNT_W-1:0] pw_cycles;

   assign pw_code = {pulse_drive_reg[`PAX_PWH_MSB:`PAX_PWH_LSB], pw_low_reg};
   // code 1023 gives 1025 us, 20500 cycles: fits sixteen bits
   assign pw_cycles = CNT_W'((32'(pw_code) + `PAX_PW_EXTRA_US) * CYC_PER_US);

   always_comb begin
      pstate_next = pstate_reg;
      pcnt_next = pcnt_reg;
      case (pstate_reg)
         PAX_PULSE_IDLE: begin
            // a refire while on is ignored; the pulse always runs full length
            if (emitter_fire) begin
               pstate_next = PAX_PULSE_ON;
               pcnt_next = pw_cycles - 1'b1;
            end
         end
         PAX_PULSE_ON: begin
            if (pcnt_reg == '0) begin
               pstate_next = PAX_PULSE_IDLE;
            end else begin
               pcnt_next = pcnt_reg - 1'b1;
            end
         end
         default: begin
            pstate_next = PAX_PULSE_IDLE;
            pcnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pstate_reg <= PAX_PULSE_IDLE;
         pcnt_reg <= '0;
      end else if (clk_en) begin
         pstate_reg <= pstate_next;
         pcnt_reg <= pcnt_next;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   logic emitter_on_reg, emitter_on_next;
   logic [4:0] total_gain_reg, total_gain_next;

   always_comb begin
      emitter_on_next = (pstate_next == PAX_PULSE_ON);
      // product of stages as a sum of exponents
      total_gain_next = 5'(first_gain_reg) +
         5'(g2_exp2x(gain_reg[`PAX_G2_MSB:`PAX_G2_LSB]));
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         emitter_on_reg <= 1'b0;
         total_gain_reg <= 5'd0;
      end else if (clk_en) begin
         emitter_on_reg <= emitter_on_next;
         total_gain_reg <= total_gain_next;
      end
   end

   assign emitter_on = emitter_on_reg;
   assign reg_rdata = rdata_reg;
   assign emitter_drive_current = pulse_drive_reg[`PAX_DRV_MSB:`PAX_DRV_LSB];
   assign prox_first_stage_gain_out = first_gain_reg;
   assign prox_second_stage_gain = gain_reg[`PAX_G2_MSB:`PAX_G2_LSB];
   assign ambient_gain = gain_reg[`PAX_AG_MSB:`PAX_AG_LSB];
   assign prox_total_gain_exp2x = total_gain_reg;
endmodule

// *** verif/paxcfg_host.sv ***
/*
 host side of the register port: one access task for reads and writes.
 assumes it is called at a rising edge of mclk.
*/
`timescale 1ns/1ps
module paxcfg_host (
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v,
      output logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // released lines flip so stale values never look valid
      reg_addr <= ~a;
      reg_wdata <= ~v;
      @(posedge mclk);
      d = reg_rdata;
   endtask
endmodule

// *** verif/paxcfg_monitor.sv ***
/*
 port checks for the register slice, bound onto paxcfg_regs.
 assumes one clock, clk_en high in normal use, synchronous reset.
*/
`timescale 1ns/1ps
module paxcfg_monitor (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic clear_on_read,
   input wire logic ambient_sat_evt,
   input wire logic prox_dark_phase_saturation,
   input wire logic prox_lit_phase_saturation,
   input wire logic prox_result_valid,
   input wire logic ambient_persist_evt,
   input wire logic calib_done_evt,
   input wire logic zero_result_evt,
   input wire logic emitter_fire,
   input wire logic emitter_on,
   input wire logic [3:0] emitter_drive_current,
   input wire logic [1:0] prox_second_stage_gain,
   input wire logic [4:0] ambient_gain
);
   logic ev;
   logic rdf;
   // any set source may refill a flag, so clears are judged only when quiet
   assign ev = ambient_sat_evt | prox_dark_phase_saturation | prox_lit_phase_saturation
      | prox_result_valid | ambient_persist_evt | calib_done_evt | zero_result_evt;
   assign rdf = clk_en && reg_rd && reg_addr == 8'h94;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   pulse_start_a: assert property (clk_en && emitter_fire && !emitter_on |=> emitter_on)
      else $error("emitter pulse did not start");
   pulse_min_a: assert property ($rose(emitter_on) |-> emitter_on [*8])
      else $error("emitter pulse too short");
   drive_field_a: assert property (clk_en && reg_wr && reg_addr == 8'h8F |=>
      {4'h0, emitter_drive_current} == ($past(reg_wdata) & 8'h0F)) else $error("drive field");
   gain_field_a: assert property (clk_en && reg_wr && reg_addr == 8'h91 |=>
      {1'b0, prox_second_stage_gain, ambient_gain} == ($past(reg_wdata) & 8'h7F))
      else $error("gain fields");
   clear_ones_a: assert property (clk_en && reg_wr && reg_addr == 8'h94 &&
      reg_wdata == 8'hFF && !ev ##1 !ev ##1 rdf |=> reg_rdata == 8'h00) else $error("w1c");
   read_clear_a: assert property (rdf && clear_on_read && !ev ##1 !ev ##1 rdf |=>
      reg_rdata == 8'h00) else $error("clear on read");
   calib_set_a: assert property (clk_en && calib_done_evt ##1 !(reg_wr || reg_rd) ##1
      rdf |=> reg_rdata[3]) else $error("calibration flag");
   dark_sat_a: assert property (clk_en && prox_dark_phase_saturation ##1
      !(reg_wr || reg_rd) ##1 rdf |=> reg_rdata[0] && reg_rdata[6]) else $error("dark sat");
endmodule
bind paxcfg_regs paxcfg_monitor u_paxcfg_monitor (.mclk, .rst, .clk_en, .reg_addr, .reg_wr,
   .reg_wdata, .reg_rd, .reg_rdata, .clear_on_read, .ambient_sat_evt,
   .prox_dark_phase_saturation, .prox_lit_phase_saturation, .prox_result_valid,
   .ambient_persist_evt, .calib_done_evt, .zero_result_evt, .emitter_fire, .emitter_on,
   .emitter_drive_current, .prox_second_stage_gain, .ambient_gain);

// *** verif/paxcfg_regs_tb.sv ***
/*
 self-checking bench: register table, fields, pulse length and flags.
 assumes paxcfg_host drives the register port; clk_en held high except for one frozen stretch.
*/
`timescale 1ns/1ps
module paxcfg_regs_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, emitter_on;
   logic cor = 1'b0;
   logic en = 1'b1;
   logic trim = 1'b1;
   logic oor = 1'b1;
   logic fire = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [3:0] pers = 4'h0;
   logic [3:0] drv;
   logic [1:0] g1, g2;
   logic [4:0] ag, tot;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   logic [7:0] ra [8] = '{8'h8F, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h8E, 8'h95};
   logic [7:0] rv [8] = '{8'h32, 8'h20, 8'h68, 8'h06, 8'hA4, 8'h00, 8'h00, 8'h00};
   logic [6:0] et [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
   logic [7:0] ef [7] = '{8'h80, 8'h41, 8'h42, 8'h20, 8'h10, 8'h08, 8'h04};
   initial begin
      forever #25 mclk = ~mclk;
   end
   // identification codes are arbitrary
   paxcfg_regs #(.REVISION_CODE(8'h06), .DEVTYPE_CODE(8'hA6)) u_paxcfg_regs (.mclk, .rst,
      .clk_en(en), .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .clear_on_read(cor),
      .ambient_sat_evt(ev[6]), .prox_dark_phase_saturation(ev[5]),
      .prox_lit_phase_saturation(ev[4]), .prox_result_valid(ev[3]), .prox_out_of_range(oor),
      .prox_persistence_count(pers), .ambient_persist_evt(ev[2]), .calib_done_evt(ev[1]),
      .automatic_offset_trim(trim), .zero_result_evt(ev[0]), .emitter_fire(fire), .emitter_on,
      .emitter_drive_current(drv), .prox_first_stage_gain_out(g1),
      .prox_second_stage_gain(g2), .ambient_gain(ag), .prox_total_gain_exp2x(tot));
   paxcfg_host u_paxcfg_host (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      u_paxcfg_host.acc(1'b0, a, 8'h00, d);
      chk(d, exp);
   endtask
   // own sink so a write never overwrites the caller's expected value
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] dummy;
      u_paxcfg_host.acc(1'b1, a, v, dummy);
   endtask
   task automatic pulse(input logic [6:0] m);
      ev <= m;
      @(posedge mclk);
      ev <= 7'h00;
      @(posedge mclk);
   endtask
   task automatic finish_test;
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      // second pass proves the read-only places ignored the writes
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
         wr(8'h92, 8'hFF);
         wr(8'h93, 8'hFF);
      end
      for (int c = 5; c <= 8; c++) begin
         wr(8'h8F, {4'h3, 4'(c)});
         chk(drv, 16'(c));
      end
      for (int j = 0; j < 3; j++) begin
         d = {1'b0, (j == 2) ? 2'd3 : 2'(j), 5'(5 + 3 * j)};
         wr(8'h91, d);
         chk({g2, ag}, d[6:0]);
         // total gain settles one edge after the gain register
         @(posedge mclk);
         chk({g1, tot}, {2'd2, 5'(2 + j)});
      end
      wr(8'h8F, 8'h78);
      wr(8'h90, 8'h00);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      n = 0;
      #1;
      while (emitter_on === 1'b1 && n < 6000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(16'(n), 16'd5160);
      @(posedge mclk);
      for (int i = 0; i < 7; i++) begin
         pulse(et[i]);
         rd(8'h94, ef[i]);
         wr(8'h94, ~ef[i]);
         rd(8'h94, ef[i]);
         wr(8'h94, (i == 6) ? 8'hFF : ef[i]);
         rd(8'h94, 8'h00);
      end
      trim <= 1'b0;
      pulse(7'h01);
      rd(8'h94, 8'h00);
      // frozen edges drop both the event and the write
      en <= 1'b0;
      pulse(7'h02);
      wr(8'h91, 8'h00);
      en <= 1'b1;
      rd(8'h94, 8'h00);
      rd(8'h91, 8'h6B);
      pers <= 4'd3;
      for (int i = 0; i < 5; i++) begin
         // first result in range flushes the count left by the flag loop
         oor <= (i != 0 && i != 2);
         pulse(7'h08);
      end
      rd(8'h94, 8'h00);
      pulse(7'h08);
      cor <= 1'b1;
      rd(8'h94, 8'h20);
      rd(8'h94, 8'h00);
      cor <= 1'b0;
      fork
         wr(8'h94, 8'hFF);
         pulse(7'h02);
      join
      rd(8'h94, 8'h08);
      finish_test();
   end
endmodule
